/* eqf_pkg.sv */
// Package for the equalizer FIR coefficient bank: register indices,
// field layout, reset values and tap positions.
// Assumes a 32-bit APB bus where each register index is one word.
package eqf_pkg;

    // Register word index width and APB byte address width.
    localparam int EQF_IDX_W   = 12;
    localparam int EQF_ADDR_W  = EQF_IDX_W + 2;
    localparam int EQF_DATA_W  = 32;
    localparam int EQF_REG_W   = 16;

    // Coefficient field and tap geometry.
    localparam int EQF_COEF_MSB = 11;
    localparam int EQF_COEF_W   = EQF_COEF_MSB + 1;
    localparam int EQF_TAP_W    = 18;
    localparam int EQF_NUM_TAPS = 9;
    localparam int EQF_CENTER   = 4;
    localparam int EQF_NUM_COEF = 6;

    // Coefficient register indices, entry 5 first, entry 0 last.
    localparam logic [EQF_NUM_COEF-1:0][EQF_IDX_W-1:0] EQF_COEF_IDX = {
        12'h44A, 12'h448, 12'h429, 12'h427, 12'h425, 12'h423
    };
    // Zero-based filter tap position served by each entry.
    localparam logic [EQF_NUM_COEF-1:0][3:0] EQF_COEF_POS = {
        4'h1, 4'h0, 4'h8, 4'h7, 4'h6, 4'h5
    };
    // Channel owning each entry: high for channel B.
    localparam logic [EQF_NUM_COEF-1:0] EQF_COEF_CHB = 6'h30;
    localparam logic [EQF_REG_W-1:0]    EQF_COEF_RST = 16'h0000;

    // Mode control and status registers.
    localparam logic [EQF_IDX_W-1:0] EQF_CTRL_IDX  = 12'h460;
    localparam logic [EQF_IDX_W-1:0] EQF_STAT_IDX  = 12'h461;
    localparam int                   EQF_SINGLE_BIT = 0;
    localparam logic                 EQF_SINGLE_RST = 1'b0;

    // Full tap vector of one filter.
    typedef logic [EQF_NUM_TAPS-1:0][EQF_TAP_W-1:0] eqf_taps_t;
    typedef logic [EQF_NUM_COEF-1:0][EQF_REG_W-1:0] eqf_coefs_t;

endpackage : eqf_pkg

/* eqf_req_if.sv */
// Interface carrying one decoded register request from the APB port
// to the register bank, and the bank's answer back.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface eqf_req_if;
    import eqf_pkg::*;

    logic                  wr;
    logic                  bad_align;
    logic [EQF_IDX_W-1:0]  idx;
    logic [EQF_REG_W-1:0]  wdata;
    logic [1:0]            strb;
    logic [EQF_DATA_W-1:0] rdata;
    logic                  err;

    modport port (output wr, bad_align, idx, wdata, strb, input rdata, err);
    modport bank (input wr, bad_align, idx, wdata, strb, output rdata, err);

endinterface : eqf_req_if

/* eqf_apb_port.sv */
// APB slave front end for the coefficient bank.
// Assumes an APB master on pclk; answers with no wait state.
`timescale 1ns/1ps
module eqf_apb_port
    import eqf_pkg::*;
(
    // Clock and reset.
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [EQF_ADDR_W-1:0] paddr,
    input  wire logic [EQF_DATA_W-1:0] pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [EQF_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Request toward the bank.
    eqf_req_if.port                    req
);
    logic [EQF_DATA_W-1:0] prdata_q;
    logic                  pslverr_q;
    wire                   setup_ph = psel & ~penable;

    // Decode is continuous; the write fires only on the access edge.
    assign req.idx       = paddr[EQF_ADDR_W-1:2];
    assign req.bad_align = |paddr[1:0];
    assign req.wdata     = pwdata[EQF_REG_W-1:0];
    assign req.strb      = pstrb[1:0];
    assign req.wr        = psel & penable & pwrite;
    assign pready        = 1'b1;
    assign prdata        = prdata_q;
    assign pslverr       = pslverr_q & psel & penable;

    // Answer is captured in setup so it stands stable through access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata_q  <= pwrite ? 32'h00000000 : req.rdata;
            pslverr_q <= req.err;
        end
    end

endmodule : eqf_apb_port

/* eqf_tap_router.sv */
// Routes the stored coefficients into the two nine-tap filter vectors.
// Assumes the remaining taps arrive full width from logic on pclk.
`timescale 1ns/1ps
module eqf_tap_router
    import eqf_pkg::*;
(
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Mode and stored coefficients.
    input  wire logic       single_mode,
    input  eqf_pkg::eqf_coefs_t coefs,
    // Taps held elsewhere.
    input  eqf_pkg::eqf_taps_t  ext_a_taps,
    input  eqf_pkg::eqf_taps_t  ext_b_taps,
    // Filter coefficient outputs.
    output eqf_pkg::eqf_taps_t  filt_a_taps,
    output eqf_pkg::eqf_taps_t  filt_b_taps,
    output logic                filt_b_en
);
    eqf_taps_t a_d;
    eqf_taps_t b_d;

    // Each owned tap replaces the outside value with its sign-extended field.
    always_comb
    begin
        a_d = ext_a_taps;
        b_d = ext_b_taps;
        for (int i = 0; i < EQF_NUM_COEF; i++)
        begin
            if (EQF_COEF_CHB[i])
                b_d[EQF_COEF_POS[i]] = {{(EQF_TAP_W-EQF_COEF_W){coefs[i][EQF_COEF_MSB]}},
                                        coefs[i][EQF_COEF_MSB:0]};
            else
                a_d[EQF_COEF_POS[i]] = {{(EQF_TAP_W-EQF_COEF_W){coefs[i][EQF_COEF_MSB]}},
                                        coefs[i][EQF_COEF_MSB:0]};
        end
        if (single_mode)
            b_d = '0;
    end

    // Outputs are registered so the filter sees one coherent set per edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filt_a_taps <= '0;
            filt_b_taps <= '0;
            filt_b_en   <= 1'b0;
        end
        else
        begin
            filt_a_taps <= a_d;
            filt_b_taps <= b_d;
            filt_b_en   <= ~single_mode;
        end
    end

endmodule : eqf_tap_router

/* eqf_coef_bank.sv */
// Top of the equalizer FIR coefficient bank: APB register file holding
// channel-A taps six to nine and channel-B taps one and two, plus mode.
// Assumes one 100 MHz pclk domain and an APB master on that clock.
//
// Summary of operation
// - Bits 11:0 of each non-center tap register are signed two's complement.
// - All tap coefficient registers clear to zero on reset.
// - Channel-A set drives filter A in dual mode, the shared filter in single.
// - Channel-A registers five to eight feed tap positions six to nine.
// - Channel-B set feeds filter B in dual mode only; index zero first tap.
// - Each filter has nine taps; center tap eighteen bits, others twelve.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module eqf_coef_bank
    import eqf_pkg::*;
(
    // Clock and reset.
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [EQF_ADDR_W-1:0] paddr,
    input  wire logic [EQF_DATA_W-1:0] pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [EQF_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Taps stored outside this bank.
    input  eqf_pkg::eqf_taps_t         ext_a_taps,
    input  eqf_pkg::eqf_taps_t         ext_b_taps,
    // Coefficient vectors for the filters.
    output eqf_pkg::eqf_taps_t         filt_a_taps,
    output eqf_pkg::eqf_taps_t         filt_b_taps,
    output logic                       filt_b_en,
    output logic                       single_mode
);
    import eqf_pkg::*;

    eqf_req_if req ();

    eqf_coefs_t            coef_q;
    logic                  single_q;
    logic [EQF_NUM_COEF-1:0] coef_hit;
    logic [EQF_NUM_COEF-1:0][EQF_REG_W-1:0] coef_rd;
    logic [EQF_REG_W-1:0]  coef_rd_any;
    wire                   ctrl_hit;
    wire                   stat_hit;
    wire                   any_hit;
    wire  [EQF_REG_W-1:0]  stat_word;

    // Bus front end; it answers every transfer with no wait state.
    eqf_apb_port u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .req     (req.port)
    );

    // One coefficient register per entry. The whole 16-bit word is stored,
    // since the upper nibble is read/write even though no logic uses it.
    // Byte strobes let software update the low byte of a tap alone.
    generate
        for (genvar g = 0; g < EQF_NUM_COEF; g++)
        begin : g_coef
            assign coef_hit[g] = ~req.bad_align & (req.idx == EQF_COEF_IDX[g]);
            assign coef_rd[g]  = coef_hit[g] ? coef_q[g] : 16'h0000;

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    coef_q[g] <= EQF_COEF_RST;
                else if (req.wr && coef_hit[g])
                begin
                    if (req.strb[0])
                        coef_q[g][7:0] <= req.wdata[7:0];
                    if (req.strb[1])
                        coef_q[g][15:8] <= req.wdata[15:8];
                end
            end
        end
    endgenerate

    // Read selection: at most one hit is high, so an OR reduction is a mux.
    always_comb
    begin
        coef_rd_any = 16'h0000;
        for (int i = 0; i < EQF_NUM_COEF; i++)
            coef_rd_any = coef_rd_any | coef_rd[i];
    end

    // Control and status decode; status mirrors the mode the filters see.
    assign ctrl_hit  = ~req.bad_align & (req.idx == EQF_CTRL_IDX);
    assign stat_hit  = ~req.bad_align & (req.idx == EQF_STAT_IDX);
    assign any_hit   = (|coef_hit) | ctrl_hit | stat_hit;
    assign stat_word = {14'h0000, filt_b_en, single_mode};

    // Unmapped or misaligned addresses answer with an error and store nothing.
    assign req.err   = ~any_hit;
    assign req.rdata = {16'h0000,
                        coef_rd_any
                        | (ctrl_hit ? {15'h0000, single_q} : 16'h0000)
                        | (stat_hit ? stat_word : 16'h0000)};

    // Mode bit: low selects dual channel, high selects single channel.
    // The status register is read-only, so writes to it are dropped.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            single_q <= EQF_SINGLE_RST;
        else if (req.wr && ctrl_hit && req.strb[0])
            single_q <= req.wdata[EQF_SINGLE_BIT];
    end

    assign single_mode = single_q;

    // Tap routing. Entries carry their own tap position, so channel-A
    // registers five to eight land on taps six to nine in either mode,
    // the channel-B pair lands on taps one and two, and each 12-bit field
    // is sign-extended into the 18-bit lane that the center tap needs.
    // The router also blanks filter B whenever single mode is selected.
    eqf_tap_router u_route (
        .pclk        (pclk),
        .presetn     (presetn),
        .single_mode (single_q),
        .coefs       (coef_q),
        .ext_a_taps  (ext_a_taps),
        .ext_b_taps  (ext_b_taps),
        .filt_a_taps (filt_a_taps),
        .filt_b_taps (filt_b_taps),
        .filt_b_en   (filt_b_en)
    );

endmodule : eqf_coef_bank

/* eqf_coef_bank_props.sv */
// Checker for the coefficient bank, watching only its top-level ports.
// Assumes one pclk domain with presetn as asynchronous active-low reset.
`timescale 1ns/1ps
module eqf_coef_bank_props
    import eqf_pkg::*;
(
    // Clock and reset.
    input wire logic                  pclk,
    input wire logic                  presetn,
    // APB slave.
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [EQF_ADDR_W-1:0] paddr,
    input wire logic [EQF_DATA_W-1:0] pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [EQF_DATA_W-1:0] prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Filter side.
    input wire eqf_taps_t             ext_a_taps,
    input wire eqf_taps_t             filt_a_taps,
    input wire eqf_taps_t             filt_b_taps,
    input wire logic                  filt_b_en,
    input wire logic                  single_mode
);
    // All checks share the bus clock and reset.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_high: assert property (pready) else $error("pready low");
    a_err_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    a_misalign_err: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    a_read_upper: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_b_en_mode: assert property ($past(presetn) |-> filt_b_en == !$past(single_mode))
        else $error("filter B enable does not follow mode");
    a_b_taps_off: assert property ($past(single_mode) |-> filt_b_taps == '0)
        else $error("filter B taps not zero in single mode");
    a_center_pass: assert property (presetn |=> filt_a_taps[EQF_CENTER] == $past(ext_a_taps[EQF_CENTER]))
        else $error("center tap not passed at full width");
    // A full write of tap seven lands, sign extended, two edges later.
    a_tap_write: assert property (psel && penable && pwrite && pstrb[1:0] == 2'b11
        && paddr == {EQF_COEF_IDX[1], 2'b00} ##0 !pslverr
        |-> ##2 filt_a_taps[EQF_COEF_POS[1]] == {{6{$past(pwdata[11], 2)}}, $past(pwdata[11:0], 2)})
        else $error("tap seven not routed from its register");
endmodule : eqf_coef_bank_props

bind eqf_coef_bank eqf_coef_bank_props eqf_coef_bank_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_a_taps(ext_a_taps), .filt_a_taps(filt_a_taps),
    .filt_b_taps(filt_b_taps), .filt_b_en(filt_b_en), .single_mode(single_mode));

/* testbench.sv */
// Self-checking bench for the coefficient bank, driven over APB.
// Assumes the checker binds itself to the top module from its own file.
`timescale 1ns/1ps
module testbench;
    import eqf_pkg::*;
    logic                  pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [EQF_ADDR_W-1:0] paddr = '0;
    logic [EQF_DATA_W-1:0] pwdata = '0, prdata, rd;
    logic [3:0]            pstrb = 4'hF;
    logic                  pready, pslverr, err, filt_b_en, single_mode;
    eqf_taps_t             ext_a_taps, ext_b_taps, filt_a_taps, filt_b_taps;
    logic [15:0]           wd [EQF_NUM_COEF];
    int                    n_mismatch = 0, checks = 0;

    // Free-running 100 MHz bus clock.
    always #5 pclk = ~pclk;

    eqf_coef_bank eqf_coef_bank_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_a_taps(ext_a_taps), .ext_b_taps(ext_b_taps),
        .filt_a_taps(filt_a_taps), .filt_b_taps(filt_b_taps), .filt_b_en(filt_b_en),
        .single_mode(single_mode));

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [EQF_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Expected filter tap: twelve-bit field sign extended to eighteen bits.
    function automatic logic [31:0] sx(input logic [15:0] v);
        return {14'h0, {6{v[11]}}, v[11:0]};
    endfunction : sx

    // Outputs are registered one edge after the store, so wait two edges.
    task automatic check_taps(input logic sgl);
        repeat (2) @(posedge pclk);
        // Sample away from the edge that launches the registered outputs.
        @(negedge pclk);
        chk(single_mode, sgl);
        chk(filt_b_en, !sgl);
        chk(filt_a_taps[EQF_CENTER], ext_a_taps[EQF_CENTER]);
        for (int i = 0; i < EQF_NUM_COEF; i++)
            if (!EQF_COEF_CHB[i])
                chk(filt_a_taps[EQF_COEF_POS[i]], sx(wd[i]));
            else
                chk(filt_b_taps[EQF_COEF_POS[i]], sgl ? 32'h0 : sx(wd[i]));
    endtask : check_taps

    task automatic end_sim();
        $display("Mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    // Main sequence.
    initial
    begin
        for (int k = 0; k < EQF_NUM_TAPS; k++)
        begin
            ext_a_taps[k] = 18'h20000 + 18'(k);
            ext_b_taps[k] = 18'h10000 + 18'(k);
        end
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < EQF_NUM_COEF; i++)
        begin
            apb(1'b0, {EQF_COEF_IDX[i], 2'b00}, '0);
            chk(rd, '0);
        end
        // Alternate signs so both branches of the extension are seen.
        for (int i = 0; i < EQF_NUM_COEF; i++)
        begin
            wd[i] = {4'h5, i[0], 11'h155 + 11'(i)};
            apb(1'b1, {EQF_COEF_IDX[i], 2'b00}, {16'h0, wd[i]});
            chk(err, 1'b0);
            apb(1'b0, {EQF_COEF_IDX[i], 2'b00}, '0);
            chk(rd, {16'h0, wd[i]});
        end
        check_taps(1'b0);
        // A misaligned write must store nothing; an unmapped read errs.
        apb(1'b1, {EQF_COEF_IDX[0], 2'b01}, 32'h0000FFFF);
        chk(err, 1'b1);
        apb(1'b0, {EQF_COEF_IDX[0], 2'b00}, '0);
        chk(rd, {16'h0, wd[0]});
        apb(1'b0, '0, '0);
        chk(err, 1'b1);
        chk(rd, '0);
        // Low-byte strobe only: the high byte of the tap must be kept.
        pstrb <= 4'h1;
        apb(1'b1, {EQF_COEF_IDX[0], 2'b00}, 32'h0000FFAA);
        pstrb <= 4'hF;
        wd[0][7:0] = 8'hAA;
        apb(1'b0, {EQF_COEF_IDX[0], 2'b00}, '0);
        chk(rd, {16'h0, wd[0]});
        // Single mode drops filter B and keeps the A set.
        apb(1'b1, {EQF_CTRL_IDX, 2'b00}, 32'h1);
        check_taps(1'b1);
        apb(1'b0, {EQF_CTRL_IDX, 2'b00}, '0);
        chk(rd, 32'h1);
        // Status is read-only: a write is dropped without an error.
        apb(1'b1, {EQF_STAT_IDX, 2'b00}, 32'h0);
        chk(err, 1'b0);
        apb(1'b0, {EQF_STAT_IDX, 2'b00}, '0);
        chk(rd, 32'h1);
        apb(1'b1, {EQF_CTRL_IDX, 2'b00}, 32'h0);
        check_taps(1'b0);
        apb(1'b0, {EQF_STAT_IDX, 2'b00}, '0);
        chk(rd, 32'h2);
        // A reset in mid-run clears the stored taps again.
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < EQF_NUM_COEF; i++)
            wd[i] = 16'h0000;
        check_taps(1'b0);
        apb(1'b0, {EQF_COEF_IDX[3], 2'b00}, '0);
        chk(rd, '0);
        end_sim();
    end

    // The tests need about a hundred cycles; this cuts off a hang.
    initial
    begin
        repeat (3000) @(posedge pclk);
        n_mismatch++;
        end_sim();
    end
endmodule : testbench
